// *** src/sgs_pkg.sv ***
// package of constants for the setting group selector
package sgs_pkg;
   localparam int          SGS_NUM_OPTO     = 16;
   localparam int          SGS_NUM_GROUPS   = 4;
   localparam int          SGS_IMG_WORDS    = 16;
   localparam int          SGS_IMG_ADDR_W   = 4;
   // register byte addresses
   localparam logic [11:0] SGS_CTRL_OFS     = 12'h000;
   localparam logic [11:0] SGS_STATUS_OFS   = 12'h004;
   localparam logic [11:0] SGS_OPTO_OFS     = 12'h008;
   localparam logic [11:0] SGS_IMG_SEL_OFS  = 12'h00c;
   localparam logic [11:0] SGS_IMG_DATA_OFS = 12'h010;
   localparam logic [11:0] SGS_IMG_OUT_OFS  = 12'h014;
   // control fields
   localparam int          SGS_CTRL_MODE_BIT  = 0;
   localparam int          SGS_CTRL_GRP_LSB   = 4;
   // image select fields
   localparam int          SGS_SEL_ADDR_LSB   = 0;
   localparam int          SGS_SEL_GRP_LSB    = 8;
   // status fields
   localparam int          SGS_STAT_GRP_LSB   = 0;
   localparam int          SGS_STAT_VALID_BIT = 4;
   localparam int          SGS_STAT_MODE_BIT  = 5;
   // reset values
   localparam logic        SGS_MODE_RST     = 1'b0;
   localparam logic [1:0]  SGS_GRP_RST      = 2'h0;
   // default stage block routing (opto index of each block signal)
   localparam int          SGS_OPTO_STG1    = 2;
   localparam int          SGS_OPTO_STG2    = 3;
   localparam int          SGS_OPTO_STG3    = 4;
   localparam int          SGS_OPTO_STG4    = 5;
   localparam int          SGS_OPTO_STG6    = 6;
   localparam int          SGS_OPTO_VOLT    = 7;
   localparam logic [31:0] SGS_IMG_RST      = 32'h0000_0000;
endpackage

// *** src/sgs_opto_sync.sv ***
// three-flop synchroniser with agreement filter for opto inputs
`timescale 1ns/10ps
`default_nettype none
module sgs_opto_sync #(
   parameter int W = 16
) (
   input  wire logic         core_clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] raw_in,
   output var  logic [W-1:0] clean_out,
   output var  logic         settled
);
   logic [W-1:0] meta_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [1:0]   fill_r;

   // meta_r is read only by s2_r
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         meta_r <= '0;
         s2_r   <= '0;
         s3_r   <= '0;
      end else begin
         meta_r <= raw_in;
         s2_r   <= meta_r;
         s3_r   <= s2_r;
      end
   end

   // a bit changes only once the second and third stages agree
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         clean_out <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               clean_out[i] <= s3_r[i];
            end
         end
      end
   end

   // settled rises once real pin levels have reached clean_out
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         fill_r  <= 2'h0;
         settled <= 1'b0;
      end else begin
         if (fill_r != 2'h3) begin
            fill_r <= fill_r + 2'h1;
         end
         settled <= (fill_r == 2'h3);
      end
   end
endmodule
`default_nettype wire

// *** src/sgs_top.sv ***
// setting group selector with per-group scheme logic images and apb registers
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Operation
// (R1) group source: opto inputs or menu setting
// (R2) optos 1,2 decode to groups 1..4
// (R3) menu mode uses stored group, ignores optos
// (R4) menu mode frees optos 1,2 for logic
// (R5) one logic image per group, active applied
// (R6) opto mode: optos 1,2 hardwired select
// (R7) default routing optos 3-8 to block signals
// (R8) image load/read names the target group
// (R9) group valid from inputs before first use
module sgs_top
   import sgs_pkg::*;
#(
   parameter int NUM_OPTO = SGS_NUM_OPTO
) (
   input  wire logic                core_clk,
   input  wire logic                resetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output var  logic [31:0]         prdata,
   output var  logic                pready,
   output var  logic                pslverr,
   input  wire logic [NUM_OPTO-1:0] opto_in,
   output var  logic [1:0]          active_group,
   output var  logic                group_valid,
   output var  logic [NUM_OPTO-1:0] programmable_scheme_logic,
   output var  logic                stage1_freq_block_input,
   output var  logic                stage2_freq_block_input,
   output var  logic                stage3_freq_block_input,
   output var  logic                stage4_freq_block_input,
   output var  logic                stage6_freq_block_input,
   output var  logic                voltage_prot_block_input,
   output var  logic [31:0]         active_image_word
);
   typedef enum logic [2:0] {
      SGS_ST_WAIT = 3'b001,
      SGS_ST_LOAD = 3'b010,
      SGS_ST_RUN  = 3'b100
   } sgs_state_e;

   logic [NUM_OPTO-1:0]       opto_clean;
   logic                      opto_settled;
   logic                      mode_menu_r;
   logic [1:0]                menu_grp_r;
   logic [SGS_IMG_ADDR_W-1:0] img_addr_r;
   logic [1:0]                img_grp_r;
   logic [SGS_IMG_ADDR_W-1:0] out_addr_r;
   logic [31:0]               image_mem [SGS_NUM_GROUPS*SGS_IMG_WORDS];
   logic [1:0]                grp_nxt;
   logic [1:0]                grp_r;
   sgs_state_e                state_r;
   logic                      wr_en;
   logic                      rd_en;
   logic                      wr_ctrl;
   logic                      wr_sel;
   logic                      wr_data;
   logic                      wr_show;
   logic                      rd_data;
   logic                      addr_ok;
   logic [31:0]               rd_nxt;

   // two opto pins select the group as a 2-bit code
   function automatic logic [1:0] opto_code(input logic o1, input logic o2);
      return {o2, o1}; // [R2]
   endfunction

   // flat index into the image array for a group and word
   function automatic logic [5:0] img_index(input logic [1:0] g, input logic [SGS_IMG_ADDR_W-1:0] a);
      return {g, a};
   endfunction

   // register decode, shared by every write strobe and the pointer step
   function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
      return a == ofs;
   endfunction

   // byte-lane merge for apb writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   sgs_opto_sync #(
      .W(NUM_OPTO)
   ) u_sync (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .raw_in    (opto_in),
      .clean_out (opto_clean),
      .settled   (opto_settled)
   );

   // apb decode, zero wait state
   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && penable && !pwrite;
   // per-register strobes; an access completes in its first access cycle
   assign wr_ctrl = wr_en && reg_hit(paddr, SGS_CTRL_OFS);
   assign wr_sel  = wr_en && reg_hit(paddr, SGS_IMG_SEL_OFS);
   assign wr_data = wr_en && reg_hit(paddr, SGS_IMG_DATA_OFS);
   assign wr_show = wr_en && reg_hit(paddr, SGS_IMG_OUT_OFS);
   assign rd_data = rd_en && reg_hit(paddr, SGS_IMG_DATA_OFS);
   always_comb begin
      addr_ok = 1'b1;
      unique case (paddr)
         SGS_CTRL_OFS, SGS_STATUS_OFS, SGS_OPTO_OFS,
         SGS_IMG_SEL_OFS, SGS_IMG_DATA_OFS, SGS_IMG_OUT_OFS: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !addr_ok;

   // group source; opto mode after reset so the pins decide at power-up
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mode_menu_r <= SGS_MODE_RST;
      end else if (wr_ctrl && pstrb[0]) begin
         mode_menu_r <= pwdata[SGS_CTRL_MODE_BIT];             // [R1]
      end
   end

   // stored menu group, kept while the pins select so a later switch is ready
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         menu_grp_r <= SGS_GRP_RST;
      end else if (wr_ctrl && pstrb[0]) begin
         menu_grp_r <= pwdata[SGS_CTRL_GRP_LSB +: 2];          // [R3]
      end
   end

   // target group of image loads and reads, named before any data moves
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         img_grp_r <= SGS_GRP_RST;
      end else if (wr_sel) begin
         img_grp_r <= pwdata[SGS_SEL_GRP_LSB +: 2];            // [R8]
      end
   end

   // word pointer steps after every data access so a bulk load needs one select
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         img_addr_r <= '0;
      end else if (wr_sel) begin
         img_addr_r <= pwdata[SGS_SEL_ADDR_LSB +: SGS_IMG_ADDR_W];
      end else if (wr_data || rd_data) begin
         img_addr_r <= img_addr_r + SGS_IMG_ADDR_W'(1); // wraps within the group
      end
   end

   // per-group image storage; no reset so it maps to memory
   always_ff @(posedge core_clk) begin
      if (wr_data) begin
         image_mem[img_index(img_grp_r, img_addr_r)] <=
            merge(image_mem[img_index(img_grp_r, img_addr_r)], pwdata, pstrb); // [R5] [R8]
      end
   end

   // select source of the active group
   always_comb begin
      if (mode_menu_r) begin
         grp_nxt = menu_grp_r;                                    // [R3]
      end else begin
         grp_nxt = opto_code(opto_clean[0], opto_clean[1]);       // [R2] [R6]
      end
   end

   // start-up sequencer: wait for trustworthy pin levels, load once, then run
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= SGS_ST_WAIT;
      end else begin
         unique case (state_r)
            SGS_ST_WAIT: begin
               if (opto_settled) begin
                  state_r <= SGS_ST_LOAD;
               end
            end
            SGS_ST_LOAD: begin
               state_r <= SGS_ST_RUN;
            end
            SGS_ST_RUN: begin
               state_r <= SGS_ST_RUN;
            end
            default: begin
               state_r <= SGS_ST_WAIT; // an upset code restarts the start-up sequence
            end
         endcase
      end
   end

   // active group follows its source once the pins are trustworthy
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         grp_r <= SGS_GRP_RST;
      end else if (state_r == SGS_ST_LOAD) begin
         grp_r <= grp_nxt;                                        // [R9]
      end else if (state_r == SGS_ST_RUN) begin
         grp_r <= grp_nxt;                                        // [R1]
      end
   end

   // valid only from the first load; until then no group-dependent logic acts
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         group_valid <= 1'b0;
      end else if (state_r == SGS_ST_LOAD) begin
         group_valid <= 1'b1;                                     // [R9]
      end else if (state_r != SGS_ST_RUN) begin
         group_valid <= 1'b0;
      end
   end
   assign active_group = grp_r;

   // scheme logic inputs: optos 1,2 only released in menu mode
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         programmable_scheme_logic <= '0;
      end else begin
         programmable_scheme_logic <= opto_clean;
         if (!mode_menu_r) begin
            programmable_scheme_logic[1:0] <= 2'h0;               // [R6]
         end else begin
            programmable_scheme_logic[1:0] <= opto_clean[1:0];    // [R4]
         end
      end
   end

   // default block routing of optos 3 to 8
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stage1_freq_block_input  <= 1'b0;
         stage2_freq_block_input  <= 1'b0;
         stage3_freq_block_input  <= 1'b0;
         stage4_freq_block_input  <= 1'b0;
         stage6_freq_block_input  <= 1'b0;
         voltage_prot_block_input <= 1'b0;
      end else begin
         stage1_freq_block_input  <= opto_clean[SGS_OPTO_STG1];   // [R7]
         stage2_freq_block_input  <= opto_clean[SGS_OPTO_STG2];   // [R7]
         stage3_freq_block_input  <= opto_clean[SGS_OPTO_STG3];   // [R7]
         stage4_freq_block_input  <= opto_clean[SGS_OPTO_STG4];   // [R7]
         stage6_freq_block_input  <= opto_clean[SGS_OPTO_STG6];   // [R7]
         voltage_prot_block_input <= opto_clean[SGS_OPTO_VOLT];   // [R7]
      end
   end

   // word of the image that software wants to watch on the output
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         out_addr_r <= '0;
      end else if (wr_show) begin
         out_addr_r <= pwdata[SGS_IMG_ADDR_W-1:0];
      end
   end

   // image word of the active group; lags a group change by one edge
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         active_image_word <= SGS_IMG_RST;
      end else begin
         // invalid group applies no image, avoiding stale logic at start-up
         active_image_word <= group_valid ? image_mem[img_index(grp_r, out_addr_r)] : SGS_IMG_RST; // [R5]
      end
   end

   // read mux; reserved bits read zero
   always_comb begin
      rd_nxt = 32'h0000_0000;
      unique case (paddr)
         SGS_CTRL_OFS: begin
            rd_nxt[SGS_CTRL_MODE_BIT]     = mode_menu_r;
            rd_nxt[SGS_CTRL_GRP_LSB +: 2] = menu_grp_r;
         end
         SGS_STATUS_OFS: begin
            rd_nxt[SGS_STAT_GRP_LSB +: 2] = grp_r;
            rd_nxt[SGS_STAT_VALID_BIT]    = group_valid;
            rd_nxt[SGS_STAT_MODE_BIT]     = mode_menu_r;
         end
         SGS_OPTO_OFS:     rd_nxt[NUM_OPTO-1:0] = opto_clean;
         SGS_IMG_SEL_OFS: begin
            rd_nxt[SGS_SEL_ADDR_LSB +: SGS_IMG_ADDR_W] = img_addr_r;
            rd_nxt[SGS_SEL_GRP_LSB +: 2]               = img_grp_r;
         end
         SGS_IMG_DATA_OFS: rd_nxt = image_mem[img_index(img_grp_r, img_addr_r)]; // [R8]
         SGS_IMG_OUT_OFS:  rd_nxt[SGS_IMG_ADDR_W-1:0] = out_addr_r;
         default:          rd_nxt = 32'h0000_0000;
      endcase
   end
   assign prdata = rd_en ? rd_nxt : 32'h0000_0000;
endmodule
`default_nettype wire

// *** tb/sgs_top_props.sv ***
// checker of group selection behaviour at the selector ports
`timescale 1ns/10ps
`default_nettype none
module sgs_top_props
   import sgs_pkg::*;
#(
   parameter int NUM_OPTO = 16
) (
   input wire logic                core_clk,
   input wire logic                resetn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [11:0]         paddr,
   input wire logic [31:0]         pwdata,
   input wire logic [3:0]          pstrb,
   input wire logic [NUM_OPTO-1:0] opto_in,
   input wire logic [1:0]          active_group,
   input wire logic                group_valid,
   input wire logic [NUM_OPTO-1:0] programmable_scheme_logic,
   input wire logic                stage1_freq_block_input,
   input wire logic                voltage_prot_block_input,
   input wire logic [31:0]         active_image_word
);
   logic                mode_r;
   logic [1:0]          grp_r;
   logic [3:0]          calm_r;
   logic [NUM_OPTO-1:0] pin_r;
   wire                 wr_ctrl = psel && penable && pwrite && paddr == SGS_CTRL_OFS;
   // shadow of the menu settings, taken from control writes
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mode_r <= 1'b0;
         grp_r  <= 2'h0;
      end else if (wr_ctrl && pstrb[0]) begin
         mode_r <= pwdata[SGS_CTRL_MODE_BIT];
         grp_r  <= pwdata[SGS_CTRL_GRP_LSB +: 2];
      end
   end
   // a quiet spell lets the pin filter settle before outputs are judged
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         calm_r <= 4'h0;
         pin_r  <= '0;
      end else begin
         pin_r  <= opto_in;
         calm_r <= (opto_in != pin_r || wr_ctrl) ? 4'h0 : calm_r + 4'(calm_r != 4'hf);
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   chk_opto_decode: assert property (
      !mode_r && calm_r > 4'd8 |-> active_group == pin_r[1:0]) else $error("pin code not decoded");
   chk_menu_group: assert property (
      mode_r && calm_r > 4'd1 |-> active_group == grp_r) else $error("menu group not applied");
   chk_menu_pass: assert property (
      mode_r && calm_r > 4'd8 |-> programmable_scheme_logic[1:0] == pin_r[1:0]) else $error("pins not passed");
   chk_opto_hardwired: assert property (
      !mode_r && calm_r > 4'd2 |-> programmable_scheme_logic[1:0] == 2'h0) else $error("select pins leaked");
   chk_stage_route: assert property (
      calm_r > 4'd8 |-> stage1_freq_block_input == pin_r[2] && voltage_prot_block_input == pin_r[7])
      else $error("block routing wrong");
   chk_valid_rise: assert property (
      $rose(resetn) |-> ##[1:6] group_valid) else $error("group not valid in time");
   chk_image_idle: assert property (
      !group_valid |-> active_image_word == 32'h0000_0000) else $error("image shown without group");
   chk_group_hold: assert property (
      group_valid && calm_r > 4'd8 |-> $stable(active_group)) else $error("group moved without cause");
   cover property (mode_r && grp_r == 2'h3 && calm_r > 4'd1);
   cover property (!mode_r && calm_r > 4'd8 && active_group == 2'h3);
   cover property ($rose(group_valid));
endmodule
bind sgs_top sgs_top_props #(.NUM_OPTO(NUM_OPTO)) sgs_top_props_inst (.core_clk(core_clk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .opto_in(opto_in), .active_group(active_group), .group_valid(group_valid),
   .programmable_scheme_logic(programmable_scheme_logic), .stage1_freq_block_input(stage1_freq_block_input),
   .voltage_prot_block_input(voltage_prot_block_input), .active_image_word(active_image_word));
`default_nettype wire

// *** tb/sgs_opto_wiring.sv ***
// station wiring model driving the opto pins
`timescale 1ns/10ps
`default_nettype none
module sgs_opto_wiring (
   input  wire logic [15:0] level,
   output var  logic [15:0] opto_in
);
   // contacts switch 3 ns after the level, which the bench changes on the core clock edge
   initial opto_in = 16'h0000;
   always @(level) opto_in <= #3 level;
endmodule
`default_nettype wire

// *** tb/sgs_top_bench.sv ***
// self-checking bench of the setting group selector
`timescale 1ns/10ps
`default_nettype none
module sgs_top_bench;
   import sgs_pkg::*;
   logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr, gv, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, iw;
   logic [15:0] level, opto_in, sch;
   logic [3:0]  strb;
   logic [5:0]  blk;
   logic [1:0]  ag;
   int          error_cnt, tests_run, seed, g, w;
   int          img[4][2];
   `define CMP(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
      $display("[FAIL] %0t got %h want %h", $time, a, b); end end
   sgs_top sgs_top_inst (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .opto_in(opto_in), .active_group(ag), .group_valid(gv),
      .programmable_scheme_logic(sch), .stage1_freq_block_input(blk[0]), .stage2_freq_block_input(blk[1]),
      .stage3_freq_block_input(blk[2]), .stage4_freq_block_input(blk[3]),
      .stage6_freq_block_input(blk[4]), .voltage_prot_block_input(blk[5]), .active_image_word(iw));
   sgs_opto_wiring sgs_opto_wiring_inst (.level(level), .opto_in(opto_in));
   task automatic give_verdict();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // one transfer; the request stands until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #300000;
      error_cnt++;
      give_verdict();
   end
   initial begin
      {psel, penable, pwrite, resetn} = 4'h0;
      paddr  = 12'h000;
      pwdata = 32'h0000_0000;
      level  = 16'h0000;
      seed   = 43;
      strb   = 4'hf;
      tick(4);
      resetn <= 1'b1;
      `CMP(gv, 1'b0)
      apb(0, SGS_CTRL_OFS, 0);
      `CMP(rd, 32'h0000_0000)
      // pin mode: every code, other pins random
      for (g = 0; g < 4; g++) begin
         level <= (16'($random(seed)) & 16'hfffc) | 16'(g);
         tick(10);
         `CMP(ag, g[1:0])
         `CMP(sch[1:0], 2'h0)
         `CMP(blk, level[7:2])
         apb(0, SGS_STATUS_OFS, 0);
         `CMP(rd[5:0], {4'b0100, g[1:0]})
         apb(0, SGS_OPTO_OFS, 0);
         `CMP(rd[15:0], level)
      end
      // menu mode: stored group wins, select pins reach the logic
      for (g = 0; g < 4; g++) begin
         apb(1, SGS_CTRL_OFS, (32'(g) << 4) | 32'h1);
         level <= 16'($random(seed));
         tick(10);
         `CMP(ag, g[1:0])
         `CMP(sch[1:0], level[1:0])
         `CMP(sch[15:2], level[15:2])
      end
      // load two words per group image, naming the group
      for (g = 0; g < 4; g++) begin
         apb(1, SGS_IMG_SEL_OFS, 32'(g) << SGS_SEL_GRP_LSB);
         for (w = 0; w < 2; w++) begin
            img[g][w] = $random(seed);
            apb(1, SGS_IMG_DATA_OFS, 32'(img[g][w]));
         end
      end
      // low byte only: the rest of the stored word must stay
      apb(1, SGS_IMG_SEL_OFS, 32'h0000_0001);
      strb <= 4'h1;
      apb(1, SGS_IMG_DATA_OFS, 32'h0000_00a5);
      strb <= 4'hf;
      img[0][1] = (img[0][1] & 32'hffff_ff00) | 32'h0000_00a5;
      apb(1, SGS_IMG_OUT_OFS, 32'h0000_0001);
      for (g = 3; g >= 0; g--) begin
         apb(1, SGS_IMG_SEL_OFS, 32'(g) << SGS_SEL_GRP_LSB);
         for (w = 0; w < 2; w++) begin
            apb(0, SGS_IMG_DATA_OFS, 0);
            `CMP(rd, 32'(img[g][w]))
         end
         apb(1, SGS_CTRL_OFS, (32'(g) << 4) | 32'h1);
         tick(3);
         `CMP(iw, 32'(img[g][1]))
      end
      // unmapped place is refused and reads nothing
      apb(1, 12'h020, 32'hffff_ffff);
      `CMP(err, 1'b1)
      apb(0, 12'h020, 0);
      `CMP({err, rd}, {1'b1, 32'h0000_0000})
      // reset in mid-run with pins set: group follows the pins again
      level  <= 16'($random(seed)) | 16'h0003;
      resetn <= 1'b0;
      tick(2);
      resetn <= 1'b1;
      tick(10);
      `CMP({gv, ag}, 3'b111)
      give_verdict();
   end
endmodule
`default_nettype wire
